//--- rtl/sdac_top.sv
// stereo dac serial audio port, serial control port and control pins
// Function
// - two channels, 16/18-bit twos complement, msb first
// - capture works with gated or burst bit clock
// - two format pins select one of four formats
// - word-length pin high 18 bits, low 16
// - control words 8 bits unsigned, msb first
// - each channel word sets own attenuation, mute
// - control data sampled on control clock rising
// - control word takes effect on latch rising edge
// - sleep-reset pin low holds sleep state
// - rising sleep-reset edge resets control defaults
// - emphasis pin high closes both emphasis switches
// - hardware mute high silences both outputs
// - formats left, i2s, right justified, dsp
// - left/right clock frames and gives rate
// - bit clock only shifts, asynchronous to master clock
`timescale 1ns/1ps
`include "sdac_defines.svh"
module sdac_top (
	input  wire logic              core_clk,              // master clock
	input  wire logic              rst_n,                 // async reset, active low
	input  wire logic              audio_bit_clock,       // serial audio bit clock
	input  wire logic              audio_lr_clock,        // left/right frame clock
	input  wire logic              audio_serial_in,       // serial audio data
	input  wire logic              format_select_0,       // format pin 0
	input  wire logic              format_select_1,       // format pin 1
	input  wire logic              word_len_18,           // high selects 18-bit words
	input  wire logic              ctrl_shift_clock,      // control shift clock
	input  wire logic              ctrl_serial_in,        // control serial data
	input  wire logic              ctrl_load_strobe,      // control latch
	input  wire logic              sleep_reset_n,         // power-down/reset pin
	input  wire logic              emphasis_enable,       // de-emphasis request
	input  wire logic              hw_mute,               // hardware mute pin
	input  wire logic              hsel,                  // ahb select
	input  wire logic [31:0]       haddr,                 // ahb address
	input  wire logic [1:0]        htrans,                // ahb transfer type
	input  wire logic              hwrite,                // ahb write
	input  wire logic [2:0]        hsize,                 // ahb size
	input  wire logic [31:0]       hwdata,                // ahb write data
	input  wire logic              hready,                // ahb bus ready
	output logic                   hreadyout,             // ahb slave ready
	output logic                   hresp,                 // ahb response
	output logic [31:0]            hrdata,                // ahb read data
	output logic [17:0]            left_sample,           // left sample, msb aligned
	output logic [17:0]            right_sample,          // right sample, msb aligned
	output logic                   sample_valid,          // pulse on new sample
	output logic                   frame_tick,            // pulse per lrclk rise
	output sdac_pkg::sdac_chan_t   left_ctrl,             // left attenuation word
	output sdac_pkg::sdac_chan_t   right_ctrl,            // right attenuation word
	output logic                   left_mute,             // left analog mute
	output logic                   right_mute,            // right analog mute
	output logic                   left_emphasis_switch,  // left emphasis switch
	output logic                   right_emphasis_switch, // right emphasis switch
	output logic                   sleep_active           // low power state
);
	import sdac_pkg::*;

	// reset release through two flops
	logic rst_s1_reg, rst_sync_n;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_sync_n <= rst_s1_reg;
		end
	end

	// bit clock domain reset, released on the bit clock
	logic brst_s1_reg, brst_n;
	always_ff @(posedge audio_bit_clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			brst_s1_reg <= 1'b0;
			brst_n      <= 1'b0;
		end else begin
			brst_s1_reg <= 1'b1;
			brst_n      <= brst_s1_reg;
		end
	end

	// format pins into bit clock domain
	sdac_fmt_t bfmt1_reg, bfmt_reg;
	always_ff @(posedge audio_bit_clock or negedge brst_n) begin
		if (!brst_n) begin
			bfmt1_reg <= '0;
			bfmt_reg  <= '0;
		end else begin
			bfmt1_reg <= '{fmt: {format_select_1, format_select_0}, wl18: word_len_18};
			bfmt_reg  <= bfmt1_reg;
		end
	end

	// serial audio capture on bit clock only
	logic        lr_d_reg;
	logic [17:0] sr_reg;
	logic [5:0]  idx_reg;
	logic [17:0] bword_reg;
	logic        bleft_reg, btog_reg;
	logic        lr_edge, restart, done, is_left;
	logic [5:0]  cur_idx, wlen;
	logic [17:0] sr_next, src, word_next;
	always_comb begin
		lr_edge = audio_lr_clock != lr_d_reg;
		wlen    = bfmt_reg.wl18 ? `SDAC_LEN18 : `SDAC_LEN16;
		restart = (bfmt_reg.fmt == `SDAC_FMT_DSP) ? (lr_edge && audio_lr_clock) : lr_edge;
		cur_idx = restart ? 6'h00 : idx_reg;
		sr_next = {sr_reg[16:0], audio_serial_in};
		done    = 1'b0;
		is_left = audio_lr_clock;
		unique case (bfmt_reg.fmt)
			`SDAC_FMT_LJ: begin
				done = cur_idx == wlen - 6'h01;
			end
			`SDAC_FMT_I2S: begin
				done    = cur_idx == wlen;
				is_left = !audio_lr_clock;
			end
			`SDAC_FMT_RJ: begin
				done    = lr_edge;
				is_left = lr_d_reg;
			end
			`SDAC_FMT_DSP: begin
				done    = (cur_idx == wlen - 6'h01) || (cur_idx == {wlen[4:0], 1'b0} - 6'h01);
				is_left = cur_idx < wlen;
			end
		endcase
		src       = (bfmt_reg.fmt == `SDAC_FMT_RJ) ? sr_reg : sr_next;
		word_next = bfmt_reg.wl18 ? src : {src[15:0], 2'b00};
	end

	// shift, count and hand words over by toggle
	always_ff @(posedge audio_bit_clock or negedge brst_n) begin
		if (!brst_n) begin
			lr_d_reg  <= 1'b0;
			sr_reg    <= '0;
			idx_reg   <= 6'h00;
			bword_reg <= '0;
			bleft_reg <= 1'b0;
			btog_reg  <= 1'b0;
		end else begin
			lr_d_reg <= audio_lr_clock;
			sr_reg   <= sr_next;
			idx_reg  <= (cur_idx == `SDAC_IDX_MAX) ? cur_idx : cur_idx + 6'h01;
			if (done) begin
				bword_reg <= word_next;
				bleft_reg <= is_left;
				btog_reg  <= !btog_reg;
			end
		end
	end

	// pins into core domain
	logic [2:0] tg_reg, lr_reg, ctrl_shift_clock_reg, clat_reg, slp_reg;
	logic [1:0] cd_reg, emp_reg, mut_reg;
	sdac_fmt_t  cfmt1_reg, cfmt_reg;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tg_reg    <= '0;
			lr_reg    <= '0;
			ctrl_shift_clock_reg  <= '0;
			clat_reg  <= '0;
			slp_reg   <= '0;
			cd_reg    <= '0;
			emp_reg   <= '0;
			mut_reg   <= '0;
			cfmt1_reg <= '0;
			cfmt_reg  <= '0;
		end else begin
			tg_reg    <= {tg_reg[1:0], btog_reg};
			lr_reg    <= {lr_reg[1:0], audio_lr_clock};
			ctrl_shift_clock_reg  <= {ctrl_shift_clock_reg[1:0], ctrl_shift_clock};
			clat_reg  <= {clat_reg[1:0], ctrl_load_strobe};
			slp_reg   <= {slp_reg[1:0], sleep_reset_n};
			cd_reg    <= {cd_reg[0], ctrl_serial_in};
			emp_reg   <= {emp_reg[0], emphasis_enable};
			mut_reg   <= {mut_reg[0], hw_mute};
			cfmt1_reg <= '{fmt: {format_select_1, format_select_0}, wl18: word_len_18};
			cfmt_reg  <= cfmt1_reg;
		end
	end

	logic word_chg, lr_rise, ctrl_shift_clock_rise, latch_rise, slp_rise;
	assign word_chg   = tg_reg[2] ^ tg_reg[1];
	assign lr_rise    = lr_reg[1] && !lr_reg[2];
	assign ctrl_shift_clock_rise  = ctrl_shift_clock_reg[1] && !ctrl_shift_clock_reg[2];
	assign latch_rise = clat_reg[1] && !clat_reg[2];
	assign slp_rise   = slp_reg[1] && !slp_reg[2];

	// captured samples, taken once the toggle has settled
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			left_sample  <= '0;
			right_sample <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= word_chg;
			if (word_chg && bleft_reg) begin
				left_sample <= bword_reg;
			end
			if (word_chg && !bleft_reg) begin
				right_sample <= bword_reg;
			end
		end
	end

	// frame rate reference: lrclk period in core cycles
	logic [15:0] per_cnt_reg, period_reg;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			per_cnt_reg <= '0;
			period_reg  <= '0;
			frame_tick  <= 1'b0;
		end else begin
			frame_tick <= lr_rise;
			if (lr_rise) begin
				period_reg  <= per_cnt_reg;
				per_cnt_reg <= 16'h0001;
			end else if (per_cnt_reg != 16'hFFFF) begin
				per_cnt_reg <= per_cnt_reg + 16'h0001;
			end
		end
	end

	// power state
	sdac_state_t state_reg;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= ST_SLEEP;
		end else begin
			unique case (state_reg)
				ST_SLEEP: state_reg <= slp_rise ? ST_WAKE : ST_SLEEP;
				ST_WAKE:  state_reg <= slp_reg[1] ? ST_RUN : ST_SLEEP;
				ST_RUN:   state_reg <= slp_reg[1] ? ST_RUN : ST_SLEEP;
			endcase
		end
	end
	assign sleep_active = state_reg == ST_SLEEP;

	// control port shifter and latch
	logic [15:0] cshift_reg;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cshift_reg <= `SDAC_CSHIFT_DEF;
			left_ctrl  <= `SDAC_CHAN_DEF;
			right_ctrl <= `SDAC_CHAN_DEF;
		end else if (state_reg != ST_RUN) begin
			cshift_reg <= `SDAC_CSHIFT_DEF;
			left_ctrl  <= `SDAC_CHAN_DEF;
			right_ctrl <= `SDAC_CHAN_DEF;
		end else begin
			if (ctrl_shift_clock_rise) begin
				cshift_reg <= {cshift_reg[14:0], cd_reg[1]};
			end
			if (latch_rise) begin
				left_ctrl  <= cshift_reg[15:8];
				right_ctrl <= cshift_reg[7:0];
			end
		end
	end

	// mute and emphasis outputs
	logic soft_mute_reg;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			left_mute             <= 1'b1;
			right_mute            <= 1'b1;
			left_emphasis_switch  <= 1'b0;
			right_emphasis_switch <= 1'b0;
		end else begin
			left_mute  <= mut_reg[1] || soft_mute_reg || left_ctrl.mute || sleep_active;
			right_mute <= mut_reg[1] || soft_mute_reg || right_ctrl.mute || sleep_active;
			left_emphasis_switch  <= emp_reg[1];
			right_emphasis_switch <= emp_reg[1];
		end
	end

	// ahb-lite slave, zero wait states
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`SDAC_ADDR_CTRL:   v[`SDAC_CTRL_MUTE] = soft_mute_reg;
			`SDAC_ADDR_STATUS: begin
				v[1:0]              = cfmt_reg.fmt;
				v[`SDAC_ST_WL18]    = cfmt_reg.wl18;
				v[`SDAC_ST_HWMUTE]  = mut_reg[1];
				v[`SDAC_ST_EMPH]    = emp_reg[1];
				v[`SDAC_ST_SLEEP]   = sleep_active;
			end
			`SDAC_ADDR_LEFT:   v[17:0] = left_sample;
			`SDAC_ADDR_RIGHT:  v[17:0] = right_sample;
			`SDAC_ADDR_CHAN:   v[15:0] = {right_ctrl, left_ctrl};
			`SDAC_ADDR_PERIOD: v[15:0] = period_reg;
			default:           v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	logic       addr_ok, wr_pend_reg;
	logic [7:0] wr_addr_reg;
	assign addr_ok   = hsel && hready && htrans == `SDAC_HTRANS_NSEQ && haddr[31:8] == 24'h0;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_pend_reg   <= 1'b0;
			wr_addr_reg   <= 8'h00;
			hrdata        <= 32'h0000_0000;
			soft_mute_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ok && hwrite;
			wr_addr_reg <= haddr[7:0];
			hrdata      <= (addr_ok && !hwrite) ? rd_mux(haddr[7:0]) : 32'h0000_0000;
			if (wr_pend_reg && wr_addr_reg == `SDAC_ADDR_CTRL) begin
				soft_mute_reg <= hwdata[`SDAC_CTRL_MUTE];
			end
		end
	end

	// checks in the core domain
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	AST_EMPH_PAIR: assert property (
		##1 (left_emphasis_switch == $past(emp_reg[1])) && (right_emphasis_switch == left_emphasis_switch))
		else $error("emphasis switches do not follow the pin");
	AST_HW_MUTE: assert property (
		mut_reg[1] |=> left_mute && right_mute)
		else $error("hardware mute did not silence both outputs");
	AST_SLEEP_HOLD: assert property (
		!slp_reg[1] |=> sleep_active ##1 !slp_reg[1] [*1] or sleep_active)
		else $error("sleep-reset low did not hold sleep");
	AST_WAKE_DEFAULT: assert property (
		slp_rise && sleep_active |=> left_ctrl == `SDAC_CHAN_DEF && right_ctrl == `SDAC_CHAN_DEF
			&& cshift_reg == `SDAC_CSHIFT_DEF)
		else $error("wake did not restore control defaults");
	AST_LATCH_ONLY: assert property (
		!$stable(left_ctrl) || !$stable(right_ctrl) |-> $past(latch_rise) || $past(state_reg != ST_RUN))
		else $error("control word changed without latch edge");
	AST_CTRL_SHIFT: assert property (
		ctrl_shift_clock_rise && state_reg == ST_RUN |=> cshift_reg[0] == $past(cd_reg[1])
			&& cshift_reg[15:1] == $past(cshift_reg[14:0]))
		else $error("control bit not shifted on clock rise");
	AST_CHAN_SPLIT: assert property (
		latch_rise && state_reg == ST_RUN |=> left_ctrl == $past(cshift_reg[15:8])
			&& right_ctrl == $past(cshift_reg[7:0]))
		else $error("channel words not taken independently");
	AST_SAMPLE_XFER: assert property (
		word_chg |=> sample_valid && ($past(bleft_reg) ? left_sample : right_sample) == $past(bword_reg))
		else $error("captured word not handed over");

	// check in the bit clock domain
	AST_RJ_EDGE: assert property (@(posedge audio_bit_clock) disable iff (!brst_n)
		lr_edge && bfmt_reg.fmt == `SDAC_FMT_RJ |=> btog_reg != $past(btog_reg)
			&& bleft_reg == $past(lr_d_reg))
		else $error("right-justified word not closed on frame edge");
endmodule

//--- pkg/sdac_defines.svh
// constants for the stereo dac serial ports block
`ifndef SDAC_DEFINES_SVH
`define SDAC_DEFINES_SVH
`define SDAC_ADDR_CTRL    8'h00
`define SDAC_ADDR_STATUS  8'h04
`define SDAC_ADDR_LEFT    8'h08
`define SDAC_ADDR_RIGHT   8'h0C
`define SDAC_ADDR_CHAN    8'h10
`define SDAC_ADDR_PERIOD  8'h14
`define SDAC_FMT_LJ       2'h0
`define SDAC_FMT_I2S      2'h1
`define SDAC_FMT_RJ       2'h2
`define SDAC_FMT_DSP      2'h3
`define SDAC_LEN16        6'h10
`define SDAC_LEN18        6'h12
`define SDAC_IDX_MAX      6'h3F
`define SDAC_CHAN_DEF     8'h00
`define SDAC_CSHIFT_DEF   16'h0000
`define SDAC_CTRL_MUTE    0
`define SDAC_ST_WL18      2
`define SDAC_ST_HWMUTE    3
`define SDAC_ST_EMPH      4
`define SDAC_ST_SLEEP     5
`define SDAC_HTRANS_NSEQ  2'h2
`endif

//--- pkg/sdac_pkg.sv
// types for the stereo dac serial ports block
package sdac_pkg;
	// per-channel control word: mute flag, spare bit, attenuation steps
	typedef struct packed {
		logic       mute;
		logic       spare;
		logic [5:0] atten;
	} sdac_chan_t;
	// static format pins after synchronising
	typedef struct packed {
		logic [1:0] fmt;
		logic       wl18;
	} sdac_fmt_t;
	// power state, one-hot
	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_WAKE  = 3'b010,
		ST_RUN   = 3'b100
	} sdac_state_t;
endpackage

//--- sim/sdac_far_model.sv
// far-side model: audio source and control host
`timescale 1ns/1ps
module sdac_far_model (
	input  wire logic core_clk,         // master clock
	output logic      audio_bit_clock,  // gated bit clock
	output logic      audio_lr_clock,   // frame clock
	output logic      audio_serial_in,  // audio data
	output logic      ctrl_shift_clock, // control clock
	output logic      ctrl_serial_in,   // control data
	output logic      ctrl_load_strobe  // control latch
);
	// idle levels, bit clock stopped
	initial begin
		audio_bit_clock = 1'b0;
		audio_lr_clock = 1'b0;
		audio_serial_in = 1'b0;
		ctrl_shift_clock = 1'b0;
		ctrl_serial_in = 1'b0;
		ctrl_load_strobe = 1'b0;
	end
	// one channel slot in a burst, clock stands still afterwards
	task automatic chan(input logic lr, input int nb, input logic [31:0] w, input int gap);
		audio_lr_clock = lr;
		for (int i = nb - 1; i >= 0; i--) begin
			audio_serial_in = w[i];
			#6 audio_bit_clock = 1'b1;
			#6 audio_bit_clock = 1'b0;
		end
		audio_serial_in = ~audio_serial_in;
		#(gap);
	endtask
	// shift a control frame, data steady across each rise
	task automatic ctrl_send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			ctrl_serial_in <= w[i];
			repeat (4) @(posedge core_clk);
			ctrl_shift_clock <= 1'b1;
			repeat (4) @(posedge core_clk);
			ctrl_shift_clock <= 1'b0;
		end
		ctrl_serial_in <= ~w[0];
	endtask
	// latch pin level
	task automatic latch(input logic v);
		ctrl_load_strobe <= v;
		repeat (4) @(posedge core_clk);
	endtask
endmodule

//--- sim/tb.sv
// self-checking bench for the stereo dac serial ports
`timescale 1ns/1ps
`include "sdac_defines.svh"
module tb;
	import sdac_pkg::*;
	logic        core_clk, rst_n, format_select_0, format_select_1, word_len_18;
	logic        sleep_reset_n, emphasis_enable, hw_mute, hsel, hwrite;
	logic        hreadyout, hresp, sample_valid, frame_tick, sleep_active;
	logic        audio_bit_clock, audio_lr_clock, audio_serial_in;
	logic        ctrl_shift_clock, ctrl_serial_in, ctrl_load_strobe;
	logic        left_mute, right_mute, left_emphasis_switch, right_emphasis_switch;
	logic [1:0]  htrans, fv;
	logic [1:0]  ord [4];
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [17:0] left_sample, right_sample, cur_l, cur_r;
	logic [7:0]  wa, wb;
	sdac_chan_t  left_ctrl, right_ctrl;
	logic [35:0] exp_q[$];
	int          n_mismatch, checks_done;
	int          n_tick, n_lr, t_lr_prev, t_lr_last;

	sdac_top dut (
		.core_clk(core_clk), .rst_n(rst_n), .audio_bit_clock(audio_bit_clock),
		.audio_lr_clock(audio_lr_clock), .audio_serial_in(audio_serial_in),
		.format_select_0(format_select_0), .format_select_1(format_select_1),
		.word_len_18(word_len_18), .ctrl_shift_clock(ctrl_shift_clock),
		.ctrl_serial_in(ctrl_serial_in), .ctrl_load_strobe(ctrl_load_strobe),
		.sleep_reset_n(sleep_reset_n), .emphasis_enable(emphasis_enable), .hw_mute(hw_mute),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .left_sample(left_sample), .right_sample(right_sample),
		.sample_valid(sample_valid), .frame_tick(frame_tick), .left_ctrl(left_ctrl),
		.right_ctrl(right_ctrl), .left_mute(left_mute), .right_mute(right_mute),
		.left_emphasis_switch(left_emphasis_switch),
		.right_emphasis_switch(right_emphasis_switch), .sleep_active(sleep_active)
	);
	sdac_far_model p (
		.core_clk(core_clk), .audio_bit_clock(audio_bit_clock),
		.audio_lr_clock(audio_lr_clock), .audio_serial_in(audio_serial_in),
		.ctrl_shift_clock(ctrl_shift_clock), .ctrl_serial_in(ctrl_serial_in),
		.ctrl_load_strobe(ctrl_load_strobe)
	);

	// master clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// bounded wait for the slave ready
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge core_clk);
		while (hreadyout !== 1'b1 && k < 20) begin
			k++;
			@(posedge core_clk);
		end
		if (k == 20) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	// one single word transfer, address phase then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= `SDAC_HTRANS_NSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk(36'(hresp), 36'h0);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(36'(r), 36'(e));
	endtask
	task automatic pins(input logic [20:0] e);
		repeat (8) @(posedge core_clk);
		chk(36'({left_ctrl, right_ctrl, left_mute, right_mute,
			left_emphasis_switch, right_emphasis_switch, sleep_active}), 36'(e));
	endtask
	// one stereo frame in format f, expectations noted first
	task automatic frame(input logic [1:0] f);
		logic [17:0] l, r;
		logic [31:0] wl, wr;
		int n, k;
		n = f[0] ? 18 : 16;
		k = (f == `SDAC_FMT_I2S) ? 1 : ((f == `SDAC_FMT_RJ) ? 2 : 0);
		l = 18'($urandom);
		r = 18'($urandom);
		wl = 32'(l) >> (18 - n);
		wr = 32'(r) >> (18 - n);
		cur_l = f[0] ? l : {l[17:2], 2'b00};
		exp_q.push_back({cur_l, cur_r});
		cur_r = f[0] ? r : {r[17:2], 2'b00};
		exp_q.push_back({cur_l, cur_r});
		if (f == `SDAC_FMT_DSP) begin
			p.chan(1'b1, 1, wl >> (n - 1), 0);
			p.chan(1'b0, n - 1, wl, 400);
		end else begin
			p.chan(f != `SDAC_FMT_I2S, n + k, wl, 400);
		end
		p.chan(f == `SDAC_FMT_I2S, n + k, wr, 400);
	endtask
	// sample watcher
	always @(posedge core_clk) begin
		if (sample_valid === 1'b1) begin
			chk({left_sample, right_sample},
				exp_q.size() ? exp_q.pop_front() : ~{left_sample, right_sample});
		end
	end
	// frame clock rises sent and frame ticks seen, short dsp pulses left out
	always @(posedge audio_lr_clock) begin
		t_lr_prev = t_lr_last;
		t_lr_last = int'($time);
		if (fv != `SDAC_FMT_DSP) n_lr++;
	end
	always @(posedge core_clk) begin
		if (frame_tick === 1'b1 && fv != `SDAC_FMT_DSP) n_tick++;
	end
	initial begin
		{rst_n, format_select_0, format_select_1, word_len_18, sleep_reset_n} = '0;
		{emphasis_enable, hw_mute, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{cur_l, cur_r} = '0;
		ord = '{`SDAC_FMT_LJ, `SDAC_FMT_DSP, `SDAC_FMT_I2S, `SDAC_FMT_RJ};
		n_mismatch = 0;
		checks_done = 0;
		n_tick = 0;
		n_lr = 0;
		t_lr_prev = 0;
		t_lr_last = 0;
		void'($urandom(79));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		pins({16'h0, 2'b11, 2'b00, 1'b1});
		p.ctrl_send(16'h8181);
		p.latch(1'b1);
		p.latch(1'b0);
		pins({16'h0, 2'b11, 2'b00, 1'b1});
		sleep_reset_n <= 1'b1;
		pins({16'h0, 2'b00, 2'b00, 1'b0});
		$display("done: sleep");
		// control words, latch edge, mutes
		wa = {2'b10, 6'($urandom)};
		wb = {2'b00, 6'($urandom)};
		p.ctrl_send({wa, wb});
		p.latch(1'b1);
		pins({wa, wb, 2'b10, 2'b00, 1'b0});
		p.ctrl_send({wb, wa});
		pins({wa, wb, 2'b10, 2'b00, 1'b0});
		p.latch(1'b0);
		p.latch(1'b1);
		pins({wb, wa, 2'b01, 2'b00, 1'b0});
		rdchk(`SDAC_ADDR_CHAN, {16'h0, wa, wb});
		for (int j = 0; j < 4; j++) begin
			fv = 2'($urandom);
			{hw_mute, emphasis_enable} <= fv;
			pins({wb, wa, fv[1], 1'b1, fv[0], fv[0], 1'b0});
		end
		hw_mute <= 1'b1;
		pins({wb, wa, 2'b11, 2'b00, 1'b0});
		hw_mute <= 1'b0;
		emphasis_enable <= 1'b1;
		pins({wb, wa, 2'b01, 2'b11, 1'b0});
		rdchk(`SDAC_ADDR_STATUS, 32'h10);
		emphasis_enable <= 1'b0;
		ahb(1'b1, `SDAC_ADDR_CTRL, 32'h1, d);
		pins({wb, wa, 2'b11, 2'b00, 1'b0});
		ahb(1'b1, `SDAC_ADDR_CTRL, 32'h0, d);
		pins({wb, wa, 2'b01, 2'b00, 1'b0});
		rdchk(8'h18, 32'h0);
		$display("done: control");
		// all four formats, both word lengths
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			fv = ord[i];
			{format_select_1, format_select_0} <= fv;
			word_len_18 <= fv[0];
			repeat (6) @(posedge core_clk);
			p.chan(audio_lr_clock, 3, 32'h0, 400);
			if (fv == `SDAC_FMT_I2S) p.chan(1'b1, 1, 32'h0, 400);
			frame(fv);
			frame(fv);
			if (fv == `SDAC_FMT_RJ) p.chan(1'b1, 1, 32'h0, 400);
			@(posedge core_clk);
			rdchk(`SDAC_ADDR_STATUS, 32'({fv[0], fv}));
			rdchk(`SDAC_ADDR_LEFT, 32'(cur_l));
			rdchk(`SDAC_ADDR_RIGHT, 32'(cur_r));
			$display("done: format %0d", fv);
		end
		// frame period in core cycles against the last two frame clock rises
		ahb(1'b0, `SDAC_ADDR_PERIOD, 32'h0, d);
		chk(36'(d * 40 < t_lr_last - t_lr_prev + 40
			&& d * 40 + 40 > t_lr_last - t_lr_prev), 36'h1);
		// back to sleep and out again
		sleep_reset_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk(36'({left_mute, right_mute, sleep_active}), 36'h7);
		rdchk(`SDAC_ADDR_STATUS, 32'h22);
		sleep_reset_n <= 1'b1;
		pins({16'h0, 2'b00, 2'b00, 1'b0});
		chk(36'(exp_q.size()), 36'h0);
		chk(36'(n_tick), 36'(n_lr));
		$display("done: wake");
		end_of_test();
	end
endmodule
